// ### hdl/ppr_regs.svh
// offsets, field positions, reset values and timing counts of the pin control block
`ifndef PPR_REGS_SVH
`define PPR_REGS_SVH

`define PPR_ADDR_W 8
`define PPR_CTRL_OFS 8'h00
`define PPR_IOSEL_OFS 8'h04
`define PPR_STATUS_OFS 8'h08
`define PPR_EVENT_OFS 8'h0C
`define PPR_STRAP_OFS 8'h10

`define PPR_CTRL_INT_ROLE 0
`define PPR_CTRL_SW_PD 1
`define PPR_CTRL_RST 2'h0

`define PPR_IOSEL_GPIO 0
`define PPR_IOSEL_OUT 1
`define PPR_IOSEL_OE 2
`define PPR_IOSEL_RST 3'h0

`define PPR_ST_PD 0
`define PPR_ST_LINK_OK 1
`define PPR_ST_LINK_1000 2
`define PPR_ST_ALARM 3
`define PPR_ST_INT 4
`define PPR_ST_WBLOCK 5
`define PPR_ST_GPIO_IN 6

`define PPR_CLK_PERIOD_NS 10
`define PPR_RESET_MIN_NS 1000
`define PPR_RESET_MIN_CYC ((`PPR_RESET_MIN_NS + `PPR_CLK_PERIOD_NS - 1) / `PPR_CLK_PERIOD_NS)
`define PPR_INT_HOLD_MS 500
`define PPR_INT_HOLD_CYC ((`PPR_INT_HOLD_MS * 1000000) / `PPR_CLK_PERIOD_NS)

`endif

// ### hdl/ppr_pkg.sv
// types of the pin control block
package ppr_pkg;
  typedef enum logic [1:0] {
    RS_RUN,
    RS_HELD
  } ppr_rst_e;
endpackage : ppr_pkg

// ### hdl/ppr_timer.sv
// saturating run-length timer: done in the limit-th cycle of run
`timescale 1ns/1ps
module ppr_timer #(
  parameter int W = 8,
  parameter int unsigned LIMIT = 100
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // control
  input wire logic run,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] count;
  } ppr_timer_s;

  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  ppr_timer_s st_r;
  ppr_timer_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt.count = '0;
    end else if (st_r.count != LAST) begin
      st_nxt.count = st_r.count + W'(1);
    end
  end

  assign done = run && (st_r.count == LAST);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : ppr_timer

// ### hdl/ppr_pin_ctrl.sv
// pin-level reset, power-down/interrupt, supply alarm and indicator control
// Function
// - drive supply alarm pin low on abnormal supply current in normal operation.
// - reset pin low at least 1 us reinitialises every internal register.
// - shared pin by default is an active-low power-down input.
// - register access keeps working during power-down.
// - in interrupt role the shared pin is an open-drain active-low interrupt.
// - with writes blocked the interrupt holds 500 ms then self-clears.
// - third indicator shows activity by default, or a selected general-purpose I/O.
// - second indicator shows a gigabit link is up.
// - first indicator shows link OK at any speed.
// - strap levels are sampled at reset release as initial configuration.
// - write-block pin low allows register writes, high blocks them.
`timescale 1ns/1ps
`include "ppr_regs.svh"
module ppr_pin_ctrl #(
  parameter int EVW = 4,
  parameter int STRAP_W = 4,
  parameter int HOLD_W = 26,
  parameter int unsigned INT_HOLD_CYCLES = `PPR_INT_HOLD_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire logic [`PPR_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // reset pin and straps
  input wire logic reset_pin_n,
  input wire logic [STRAP_W-1:0] strap_pins_in,
  output logic pin_reset_active,
  // management write block pin
  input wire logic mgmt_write_block,
  // shared power-down / interrupt pin
  input wire logic power_down_request_n_in,
  output logic power_down_request_n_out,
  output logic power_down_request_n_oe,
  output logic power_down_mode,
  // supply current alarm pin
  input wire logic supply_current_abnormal,
  output logic supply_current_alarm_n_out,
  output logic supply_current_alarm_n_oe,
  // event sources and link status
  input wire logic [EVW-1:0] event_in,
  input wire logic link_ok,
  input wire logic link_1000,
  input wire logic rxtx_activity,
  // indicators
  output logic link_ok_indicator,
  output logic link_ok_indicator_oe,
  output logic gigabit_link_indicator,
  output logic gigabit_link_indicator_oe,
  input wire logic activity_indicator_in,
  output logic activity_indicator_out,
  output logic activity_indicator_oe
);
  typedef struct packed {
    ppr_pkg::ppr_rst_e rs;
    logic [1:0] ctrl;
    logic [2:0] io_function_select;
    logic [EVW-1:0] events;
    logic [STRAP_W-1:0] straps;
    logic strap_valid;
    logic pd;
    logic alarm;
    logic led0;
    logic led1;
    logic led2;
    logic led2_oe;
    logic hold_clr;
    logic [31:0] rdata;
  } ppr_state_s;

  ppr_state_s st_r;
  ppr_state_s st_nxt;
  logic rst_done;
  logic hold_run;
  logic hold_done;
  logic wr_ok;
  logic int_role;
  logic int_pend;

  function automatic logic [31:0] zext(input logic [31:0] v);
    zext = v;
  endfunction : zext

  // pulses shorter than the minimum never reach the done count
  ppr_timer #(
    .W(8),
    .LIMIT(`PPR_RESET_MIN_CYC)
  ) u_rst_timer (
    .clock(clock),
    .reset(reset),
    .run(!reset_pin_n),
    .done(rst_done)
  );

  ppr_timer #(
    .W(HOLD_W),
    .LIMIT(INT_HOLD_CYCLES)
  ) u_hold_timer (
    .clock(clock),
    .reset(reset),
    .run(hold_run),
    .done(hold_done)
  );

  assign int_role = st_r.ctrl[`PPR_CTRL_INT_ROLE];
  assign int_pend = |st_r.events;
  // writes refused while the block pin is high or the pin reset is holding
  assign wr_ok = reg_we && !mgmt_write_block && (st_r.rs == ppr_pkg::RS_RUN);
  // without write access nobody can clear, so the timer does it
  assign hold_run = int_role && int_pend && mgmt_write_block && (st_r.rs == ppr_pkg::RS_RUN)
                    && !st_r.hold_clr;

  always_comb begin
    logic [EVW-1:0] clr;
    clr = '0;
    st_nxt = st_r;
    if (wr_ok && reg_addr == `PPR_CTRL_OFS) begin
      st_nxt.ctrl = reg_wdata[1:0];
    end else if (wr_ok && reg_addr == `PPR_IOSEL_OFS) begin
      st_nxt.io_function_select = reg_wdata[2:0];
    end else if (wr_ok && reg_addr == `PPR_EVENT_OFS) begin
      clr = reg_wdata[EVW-1:0];
    end
    if (hold_done) begin
      clr = '1;
    end
    // one idle cycle after a self-clear, so an event arriving with it gets a full hold
    st_nxt.hold_clr = hold_done;
    // set wins over a clear in the same cycle
    st_nxt.events = (st_r.events & ~clr) | event_in;
    // reads stay alive in power-down; only the pin reset stops them
    if (reg_re) begin
      if (reg_addr == `PPR_CTRL_OFS) begin
        st_nxt.rdata = zext({30'h0, st_r.ctrl});
      end else if (reg_addr == `PPR_IOSEL_OFS) begin
        st_nxt.rdata = zext({29'h0, st_r.io_function_select});
      end else if (reg_addr == `PPR_STATUS_OFS) begin
        st_nxt.rdata = zext({25'h0, activity_indicator_in, mgmt_write_block, int_role && int_pend,
                             st_r.alarm, link_1000, link_ok, st_r.pd});
      end else if (reg_addr == `PPR_EVENT_OFS) begin
        st_nxt.rdata = zext(32'(st_r.events));
      end else if (reg_addr == `PPR_STRAP_OFS) begin
        st_nxt.rdata = zext(32'(st_r.straps));
      end else begin
        st_nxt.rdata = 32'h0;
      end
    end
    st_nxt.pd = (!int_role && !power_down_request_n_in) || st_r.ctrl[`PPR_CTRL_SW_PD];
    st_nxt.alarm = supply_current_abnormal && !st_r.pd && (st_r.rs == ppr_pkg::RS_RUN);
    st_nxt.led0 = link_ok;
    st_nxt.led1 = link_ok && link_1000;
    if (st_r.io_function_select[`PPR_IOSEL_GPIO]) begin
      st_nxt.led2 = st_r.io_function_select[`PPR_IOSEL_OUT];
      st_nxt.led2_oe = st_r.io_function_select[`PPR_IOSEL_OE];
    end else begin
      st_nxt.led2 = rxtx_activity;
      st_nxt.led2_oe = 1'b1;
    end
    // first cycle after the asynchronous reset catches the straps
    if (!st_r.strap_valid) begin
      st_nxt.straps = strap_pins_in;
      st_nxt.strap_valid = 1'b1;
    end
    case (st_r.rs)
      ppr_pkg::RS_RUN: begin
        if (rst_done) begin
          st_nxt.rs = ppr_pkg::RS_HELD;
        end
      end
      ppr_pkg::RS_HELD: begin
        if (reset_pin_n) begin
          st_nxt.rs = ppr_pkg::RS_RUN;
          st_nxt.straps = strap_pins_in;
        end
      end
      default: begin
        st_nxt.rs = ppr_pkg::RS_RUN;
      end
    endcase
    // reinitialise everything while the pin reset is in force
    if (rst_done || (st_r.rs == ppr_pkg::RS_HELD && !reset_pin_n)) begin
      st_nxt.ctrl = `PPR_CTRL_RST;
      st_nxt.io_function_select = `PPR_IOSEL_RST;
      st_nxt.events = '0;
      st_nxt.rdata = 32'h0;
      st_nxt.pd = 1'b0;
      st_nxt.alarm = 1'b0;
      st_nxt.led0 = 1'b0;
      st_nxt.led1 = 1'b0;
      st_nxt.led2 = 1'b0;
      st_nxt.led2_oe = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign pin_reset_active = (st_r.rs == ppr_pkg::RS_HELD);
  assign power_down_mode = st_r.pd;
  assign power_down_request_n_out = 1'b0;
  assign power_down_request_n_oe = int_role && int_pend;
  assign supply_current_alarm_n_out = 1'b0;
  assign supply_current_alarm_n_oe = st_r.alarm;
  // indicator pins float during the pin reset so straps can be read on them
  assign link_ok_indicator = st_r.led0;
  assign link_ok_indicator_oe = !pin_reset_active;
  assign gigabit_link_indicator = st_r.led1;
  assign gigabit_link_indicator_oe = !pin_reset_active;
  assign activity_indicator_out = st_r.led2;
  assign activity_indicator_oe = st_r.led2_oe && !pin_reset_active;

  // helper: consecutive low samples of the reset pin, saturating
  logic [7:0] low_cnt_h;
  localparam logic [7:0] RST_MIN_H = 8'(`PPR_RESET_MIN_CYC);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      low_cnt_h <= 8'h0;
    end else if (reset_pin_n) begin
      low_cnt_h <= 8'h0;
    end else if (low_cnt_h != RST_MIN_H) begin
      low_cnt_h <= low_cnt_h + 8'h1;
    end
  end

  property p_alarm_on;
    @(posedge clock) disable iff (reset)
    supply_current_abnormal && !st_r.pd && st_r.rs == ppr_pkg::RS_RUN && !rst_done
      |=> supply_current_alarm_n_oe;
  endproperty
  a_alarm_on: assert property (p_alarm_on) else $error("alarm not driven");

  property p_alarm_off;
    @(posedge clock) disable iff (reset)
    !supply_current_abnormal |=> !supply_current_alarm_n_oe;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm driven without cause");

  property p_rst_min;
    @(posedge clock) disable iff (reset)
    (low_cnt_h == RST_MIN_H) == pin_reset_active || reset_pin_n && $past(low_cnt_h == RST_MIN_H);
  endproperty
  a_rst_min: assert property (p_rst_min) else $error("pin reset length wrong");

  property p_reinit;
    @(posedge clock) disable iff (reset)
    pin_reset_active && !reset_pin_n |-> st_r.ctrl == `PPR_CTRL_RST && st_r.events == '0 && !st_r.pd;
  endproperty
  a_reinit: assert property (p_reinit) else $error("registers not reinitialised");

  property p_pd;
    @(posedge clock) disable iff (reset)
    !int_role && !power_down_request_n_in && st_r.rs == ppr_pkg::RS_RUN && !rst_done |=> power_down_mode;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down not entered");

  property p_pd_read;
    @(posedge clock) disable iff (reset)
    st_r.pd && reg_re && reg_addr == `PPR_STATUS_OFS && !rst_done && st_r.rs == ppr_pkg::RS_RUN
      |=> reg_rdata[`PPR_ST_PD];
  endproperty
  a_pd_read: assert property (p_pd_read) else $error("status read lost in power-down");

  property p_int;
    @(posedge clock) disable iff (reset)
    int_role && event_in != '0 && !rst_done && !wr_ok |=> power_down_request_n_oe;
  endproperty
  a_int: assert property (p_int) else $error("interrupt not asserted");

  property p_selfclr;
    @(posedge clock) disable iff (reset)
    hold_done && event_in == '0 |=> !power_down_request_n_oe;
  endproperty
  a_selfclr: assert property (p_selfclr) else $error("interrupt did not self-clear");

  property p_wblock;
    @(posedge clock) disable iff (reset)
    reg_we && mgmt_write_block && !rst_done && st_r.rs == ppr_pkg::RS_RUN
      |=> $stable(st_r.ctrl) && $stable(st_r.io_function_select);
  endproperty
  a_wblock: assert property (p_wblock) else $error("write not blocked");

  property p_leds;
    @(posedge clock) disable iff (reset)
    st_r.rs == ppr_pkg::RS_RUN && !rst_done
      |=> link_ok_indicator == $past(link_ok) && gigabit_link_indicator == $past(link_ok && link_1000);
  endproperty
  a_leds: assert property (p_leds) else $error("link indicators wrong");

  // the oe flop stays clear until the first edge after reset release, then loads on every edge
  property p_act;
    @(posedge clock) disable iff (reset)
    st_r.io_function_select == `PPR_IOSEL_RST && st_r.rs == ppr_pkg::RS_RUN && !rst_done && st_r.strap_valid
      |=> activity_indicator_out == $past(rxtx_activity) && activity_indicator_oe;
  endproperty
  a_act: assert property (p_act) else $error("activity indicator wrong");

  property p_strap;
    @(posedge clock) disable iff (reset)
    pin_reset_active && reset_pin_n |=> st_r.straps == $past(strap_pins_in);
  endproperty
  a_strap: assert property (p_strap) else $error("straps not captured");

  property p_int_clr;
    @(posedge clock) disable iff (reset)
    int_role && wr_ok && reg_addr == `PPR_EVENT_OFS && (reg_wdata[EVW-1:0] & st_r.events) == st_r.events
      && event_in == '0 && !rst_done |=> !power_down_request_n_oe;
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("interrupt not released by clear");

  // the hold timer must start from zero again after every self-clear
  property p_hold_restart;
    @(posedge clock) disable iff (reset)
    hold_done |=> !hold_done;
  endproperty
  a_hold_restart: assert property (p_hold_restart) else $error("hold timer not restarted");

  property p_sw_pd;
    @(posedge clock) disable iff (reset)
    st_r.ctrl[`PPR_CTRL_SW_PD] && st_r.rs == ppr_pkg::RS_RUN && !rst_done |=> power_down_mode;
  endproperty
  a_sw_pd: assert property (p_sw_pd) else $error("software power-down not entered");

  property p_pd_exit;
    @(posedge clock) disable iff (reset)
    !st_r.ctrl[`PPR_CTRL_SW_PD] && (int_role || power_down_request_n_in) && st_r.rs == ppr_pkg::RS_RUN
      && !rst_done |=> !power_down_mode;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down not left");

  c_pin_reset: cover property (@(posedge clock) disable iff (reset) $rose(pin_reset_active));
  c_self_clear: cover property (@(posedge clock) disable iff (reset) hold_done);
  c_power_down: cover property (@(posedge clock) disable iff (reset) $rose(power_down_mode));
  c_alarm: cover property (@(posedge clock) disable iff (reset) $rose(supply_current_alarm_n_oe));
  c_int_clear: cover property (@(posedge clock) disable iff (reset) $fell(power_down_request_n_oe));
endmodule : ppr_pin_ctrl

// ### tb/ppr_host_model.sv
// host side model: drives the reset pin and power-down request, resolves the shared pin
`timescale 1ns/1ps
module ppr_host_model (
  // clock
  input wire logic clock,
  // shared pin as driven by the device
  input wire logic int_oe,
  input wire logic int_out,
  // pins toward the device
  output logic pin_level,
  output logic reset_pin_n
);
  logic pd_n = 1'b1;
  initial reset_pin_n = 1'b1;
  // the pull-up wins whenever nobody pulls the pin low
  assign pin_level = int_oe ? int_out : pd_n;
  task automatic request_pd(input logic on);
    @(posedge clock);
    pd_n <= !on;
  endtask : request_pd
  // hold the reset pin low for a number of sampled edges
  task automatic pulse_reset(input int cyc);
    @(posedge clock);
    reset_pin_n <= 1'b0;
    repeat (cyc) @(posedge clock);
    reset_pin_n <= 1'b1;
  endtask : pulse_reset
endmodule : ppr_host_model

// ### tb/tb_top.sv
// self-checking bench of the pin control block
`timescale 1ns/1ps
`include "ppr_regs.svh"
module tb_top;
  logic clock, reset, reg_we, reg_re, reset_pin_n, pin_reset_active, mgmt_write_block, pin_level;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, m_iosel, m_ev, r;
  logic pd_out, pd_oe, power_down_mode, supply_current_abnormal, al_out, al_oe;
  logic [3:0] event_in, strap;
  logic link_ok, link_1000, rxtx_activity, ind0, ind0_oe, ind1, ind1_oe, act_in, act_out, act_oe;
  logic alarm_wire;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed_v;
  // released alarm pin floats to its pull-up, the third indicator to its pull-down
  assign alarm_wire = al_oe ? al_out : 1'b1;
  assign act_in = act_oe ? act_out : 1'b0;
  ppr_pin_ctrl #(.INT_HOLD_CYCLES(20)) i_dut (
    .clock, .reset, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .reset_pin_n,
    .strap_pins_in(strap), .pin_reset_active, .mgmt_write_block,
    .power_down_request_n_in(pin_level), .power_down_request_n_out(pd_out),
    .power_down_request_n_oe(pd_oe), .power_down_mode, .supply_current_abnormal,
    .supply_current_alarm_n_out(al_out), .supply_current_alarm_n_oe(al_oe), .event_in,
    .link_ok, .link_1000, .rxtx_activity, .link_ok_indicator(ind0), .link_ok_indicator_oe(ind0_oe),
    .gigabit_link_indicator(ind1), .gigabit_link_indicator_oe(ind1_oe), .activity_indicator_in(act_in),
    .activity_indicator_out(act_out), .activity_indicator_oe(act_oe)
  );
  ppr_host_model i_host (.clock(clock), .int_oe(pd_oe), .int_out(pd_out), .pin_level(pin_level),
    .reset_pin_n(reset_pin_n));
  task automatic final_report;
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask : wr
  // read data is only promised in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rdc
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    reset = 1'b1;
    {reg_we, reg_re, mgmt_write_block, supply_current_abnormal, link_ok, link_1000, rxtx_activity} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    event_in = 4'h0;
    seed_v = $urandom(32'h02B1);
    strap = 4'($urandom);
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    m_iosel = 32'h0;
    rdc(`PPR_CTRL_OFS, 32'h0);
    rdc(`PPR_IOSEL_OFS, m_iosel);
    rdc(8'h20, 32'h0);
    rdc(`PPR_STATUS_OFS, 32'h0);
    rdc(`PPR_STRAP_OFS, {28'h0, strap});
    repeat (8) begin
      r = $urandom;
      @(posedge clock);
      link_ok <= r[0];
      link_1000 <= r[1];
      rxtx_activity <= r[2];
      tick(2);
      chk({ind0, ind1, act_out, ind0_oe, ind1_oe}, {r[0], r[0] & r[1], r[2], 2'b11});
    end
    m_iosel = 32'h5 | {30'h0, r[3], 1'b0};
    wr(`PPR_IOSEL_OFS, m_iosel);
    tick(2);
    chk({act_out, act_oe, act_in}, {r[3], 1'b1, r[3]});
    rdc(`PPR_IOSEL_OFS, m_iosel);
    @(posedge clock);
    {link_ok, link_1000, rxtx_activity} <= 3'b000;
    supply_current_abnormal <= 1'b1;
    tick(2);
    chk(alarm_wire, 1'b0);
    i_host.request_pd(1'b1);
    tick(3);
    chk({power_down_mode, alarm_wire}, 2'b11);
    @(posedge clock);
    supply_current_abnormal <= 1'b0;
    m_iosel = 32'h0;
    wr(`PPR_IOSEL_OFS, m_iosel);
    rdc(`PPR_IOSEL_OFS, m_iosel);
    rdc(`PPR_STATUS_OFS, 32'h1);
    i_host.request_pd(1'b0);
    tick(3);
    chk(power_down_mode, 1'b0);
    wr(`PPR_CTRL_OFS, 32'h2);
    tick(2);
    chk(power_down_mode, 1'b1);
    wr(`PPR_CTRL_OFS, 32'h1);
    r = $urandom;
    m_ev = 32'h1 << r[1:0];
    @(posedge clock);
    event_in <= m_ev[3:0];
    @(posedge clock);
    event_in <= 4'h0;
    tick(1);
    chk(pin_level, 1'b0);
    chk(power_down_mode, 1'b0);
    rdc(`PPR_EVENT_OFS, m_ev);
    wr(`PPR_EVENT_OFS, m_ev);
    tick(1);
    chk(pin_level, 1'b1);
    // with writes blocked the pending event cannot be cleared by software
    @(posedge clock);
    mgmt_write_block <= 1'b1;
    event_in <= 4'h8;
    @(posedge clock);
    event_in <= 4'h0;
    wr(`PPR_EVENT_OFS, 32'hF);
    tick(5);
    chk(pin_level, 1'b0);
    rdc(`PPR_STATUS_OFS, 32'h30);
    tick(20);
    chk(pin_level, 1'b1);
    wr(`PPR_CTRL_OFS, 32'h0);
    rdc(`PPR_CTRL_OFS, 32'h1);
    @(posedge clock);
    mgmt_write_block <= 1'b0;
    m_iosel = 32'h7;
    wr(`PPR_IOSEL_OFS, m_iosel);
    i_host.pulse_reset(50);
    tick(2);
    rdc(`PPR_IOSEL_OFS, m_iosel);
    @(posedge clock);
    strap <= 4'($urandom);
    fork
      i_host.pulse_reset(110);
      begin
        tick(105);
        chk({pin_reset_active, ind0_oe}, 2'b10);
      end
    join
    tick(2);
    rdc(`PPR_IOSEL_OFS, 32'h0);
    rdc(`PPR_CTRL_OFS, 32'h0);
    rdc(`PPR_STRAP_OFS, {28'h0, strap});
    final_report();
  end
endmodule : tb_top
